// File: tsr_top.v
// temperature sensor digital side: conversion sequencer and serial slave port
`timescale 1ns/10ps
`include "tsr_defs.vh"
module tsr_top #(
    parameter [31:0] TICK_CYC = `TSR_TICK_CYC,
    parameter [31:0] CONV_CYC = `TSR_CONV_CYC
) (
    input  wire        ref_clk,
    input  wire        resetn,
    input  wire        clk_en,
    input  wire        cs_n,
    input  wire        sclk,
    input  wire        din,
    output reg         dout,
    output wire        dout_oe,
    input  wire [13:0] adc_code,
    output reg         analog_on,
    output wire        shutdown,
    output reg  [13:0] temperature_value,
    output reg  [15:0] control_word
);
    // synchronised pins
    wire cs_n_s;
    wire sclk_s;
    wire din_s;
    reg  sclk_d;
    reg  cs_n_d;

    // serial port state
    reg  [4:0]  bit_cnt;
    reg  [15:0] shift_in;
    reg  [15:0] shift_out;
    reg         first_fall;
    reg         pd_mode;

    // conversion sequencer state
    reg  [31:0] tick_cnt;
    reg  [31:0] conv_cnt;
    reg         converting;
    reg  [13:0] buffer;
    reg         start_req;

    // fifo between converter and buffer register
    wire        fifo_in_ready;
    wire        fifo_out_valid;
    wire [13:0] fifo_out_data;
    reg         conv_done;
    reg  [13:0] conv_result;

    wire sel;
    wire rise;
    wire fall;
    wire frame_end;
    wire frame_word;
    wire [15:0] next_ctl;
    wire        tick_end;
    wire        conv_end;
    wire        launch;

    // last count of a period; shared by the tick and conversion timers
    function at_limit;
        input [31:0] cnt;
        input [31:0] lim;
        begin
            at_limit = (cnt == lim - 32'h1);
        end
    endfunction

    // frame image: the first lead zero is driven directly, this holds the second
    function [15:0] frame_load;
        input [13:0] val;
        begin
            frame_load = {1'b0, val, 1'b0};
        end
    endfunction

    tsr_sync #(.RST_VAL(1'b1)) u_sync_cs (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .clk_en  (clk_en),
        .din     (cs_n),
        .dout    (cs_n_s)
    );

    // clock idles high, so reset to that level to avoid a false edge
    tsr_sync #(.RST_VAL(1'b1)) u_sync_sclk (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .clk_en  (clk_en),
        .din     (sclk),
        .dout    (sclk_s)
    );

    tsr_sync #(.RST_VAL(1'b0)) u_sync_din (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .clk_en  (clk_en),
        .din     (din),
        .dout    (din_s)
    );

    // edges of the sampled pins; the serial clock counts only when selected
    assign sel       = ~cs_n_s;                         // R24
    assign rise      = sel & sclk_s & ~sclk_d;          // R17
    assign fall      = sel & ~sclk_s & sclk_d;          // R17
    assign frame_end = ~cs_n_d & cs_n_s;
    assign dout_oe   = sel;                             // R14
    assign shutdown  = pd_mode;
    assign next_ctl  = {shift_in[14:0], din_s};
    assign frame_word = rise && (bit_cnt == `TSR_FRAME_BITS - 5'h01);
    assign tick_end  = at_limit(tick_cnt, TICK_CYC);               // R1
    assign conv_end  = at_limit(conv_cnt, CONV_CYC);               // R2
    assign launch    = ~pd_mode & (start_req | tick_end) & ~converting; // R3 R9

    // delayed copies for edge detection, reset to the idle pin levels
    always @(posedge ref_clk) begin
        if (!resetn) begin
            sclk_d <= 1'b1;
            cs_n_d <= 1'b1;
        end else if (clk_en) begin
            sclk_d <= sclk_s;
            cs_n_d <= cs_n_s;
        end
    end

    // input shifter and control register; rising edges only
    always @(posedge ref_clk) begin
        if (!resetn) begin
            bit_cnt      <= 5'h00;
            shift_in     <= 16'h0000;
            control_word <= 16'h0000;
            pd_mode      <= 1'b0;
        end else if (clk_en) begin
            if (!sel) begin
                bit_cnt <= 5'h00;                       // R25 R21
            end else if (rise) begin
                shift_in <= next_ctl;                   // R16
                if (frame_word) begin
                    bit_cnt      <= 5'h00;              // R13
                    control_word <= next_ctl;           // R20
                    pd_mode      <= next_ctl[`TSR_PD_BIT]; // R18 R4
                end else begin
                    bit_cnt <= bit_cnt + 5'h01;
                end
            end
        end
    end

    // output shifter: two zeros then value msb first, reloaded every 16 bits
    always @(posedge ref_clk) begin
        if (!resetn) begin
            shift_out         <= 16'h0000;
            dout              <= 1'b0;
            first_fall        <= 1'b1;
            temperature_value <= 14'h0000;
        end else if (clk_en) begin
            if (!sel) begin
                first_fall <= 1'b1;
                dout       <= 1'b0;
            end else if (fall) begin
                first_fall <= 1'b0;
                if (first_fall) begin
                    // value refreshed from buffer only here, so a frame reads one snapshot
                    temperature_value <= buffer;                    // R6 R8 R5
                    shift_out <= frame_load(buffer);                // R12 R23
                    dout      <= 1'b0;                              // R15
                end else if (bit_cnt == 5'h00) begin
                    shift_out <= frame_load(temperature_value);     // R13
                    dout      <= 1'b0;
                end else begin
                    dout      <= shift_out[15];                     // R15 R23
                    shift_out <= {shift_out[14:0], 1'b0};
                end
            end
        end
    end

    // start request: a new event wins over the drop, busy requests fade next cycle
    always @(posedge ref_clk) begin
        if (!resetn) begin
            start_req <= 1'b1;
        end else if (clk_en) begin
            if (frame_word && pd_mode && !next_ctl[`TSR_PD_BIT])
                start_req <= 1'b1;                          // R4
            else if (frame_end && !pd_mode)
                start_req <= 1'b1;                          // R9
            else if (converting || launch)
                start_req <= 1'b0;                          // R9 drop when busy
        end
    end

    // one-second tick; held at zero in shutdown, restarted by any request
    always @(posedge ref_clk) begin
        if (!resetn) begin
            tick_cnt <= 32'h00000000;
        end else if (clk_en) begin
            if (pd_mode || start_req || tick_end)
                tick_cnt <= 32'h00000000;                   // R3 R1 R9
            else
                tick_cnt <= tick_cnt + 32'h1;
        end
    end

    // conversion: runs to completion whatever the port or mode does
    always @(posedge ref_clk) begin
        if (!resetn) begin
            conv_cnt    <= 32'h00000000;
            converting  <= 1'b0;
            analog_on   <= 1'b0;
            conv_done   <= 1'b0;
            conv_result <= 14'h0000;
        end else if (clk_en) begin
            conv_done <= 1'b0;
            if (launch) begin
                converting <= 1'b1;                         // R1 R4
                analog_on  <= 1'b1;
                conv_cnt   <= 32'h00000000;
            end else if (converting) begin
                if (!conv_end) begin
                    conv_cnt <= conv_cnt + 32'h1;           // R7
                end else if (fifo_in_ready) begin
                    // a full fifo stalls the end rather than losing a result
                    converting  <= 1'b0;                    // R2
                    analog_on   <= 1'b0;
                    conv_done   <= 1'b1;
                    conv_result <= adc_code;                // R10 R11
                end
            end
        end
    end

    tsr_fifo #(
        .WIDTH (`TSR_VAL_W),
        .DEPTH (`TSR_FIFO_DEPTH),
        .AW    (`TSR_FIFO_AW)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .clk_en    (clk_en),
        .in_valid  (conv_done),
        .in_ready  (fifo_in_ready),
        .in_data   (conv_result),
        .out_valid (fifo_out_valid),
        .out_ready (1'b1),
        .out_data  (fifo_out_data)
    );

    // results land in the buffer register, never straight in the value
    always @(posedge ref_clk) begin
        if (!resetn)
            buffer <= 14'h0000;
        else if (clk_en && fifo_out_valid)
            buffer <= fifo_out_data;                        // R6
    end
endmodule // tsr_top

// File: tsr_defs.vh
// constants for the temperature sensor serial readout block
// Functional notes
// (R1) normal mode converts every one-second tick
// (R2) conversion lasts 800 us, then result ready
// (R3) shutdown stops oscillator and new conversions
// (R4) all-zero control word exits shutdown, converts
// (R5) last result still readable in shutdown
// (R6) buffer copied to value at first fall
// (R7) conversion always runs to completion
// (R8) unfinished conversion stays in buffer only
// (R9) frame end restarts timer, new conversion
// (R10) value register 14 bits, bit 13 sign
// (R11) twos complement, 1/32 degree per count
// (R12) frame: two zeros then 14 data bits
// (R13) further 16 clocks repeat the frame
// (R14) output released while select is high
// (R15) output bit changes on falling clock
// (R16) input sampled on rising clock
// (R17) serial clock ignored unless selected
// (R18) third input bit is power-down request
// (R19) host drives other input bits zero
// (R20) control loaded on 16th rising edge
// (R21) early deselect leaves control unchanged
// (R22) input may be tied low, read-only
// (R23) data shifted most significant bit first
// (R24) selected only while select is low
// (R25) bit counter cleared on deselect
`ifndef TSR_DEFS_VH
`define TSR_DEFS_VH
`define TSR_CLK_MHZ       250
`define TSR_TICK_US       1000000
`define TSR_TICK_CYC      (`TSR_TICK_US * `TSR_CLK_MHZ)
`define TSR_CONV_US       800
`define TSR_CONV_CYC      (`TSR_CONV_US * `TSR_CLK_MHZ)
`define TSR_VAL_W         14
`define TSR_SIGN_POS      13
`define TSR_CTL_W         16
`define TSR_FRAME_BITS    5'h10
`define TSR_PD_BIT        13
`define TSR_FIFO_DEPTH    8
`define TSR_FIFO_AW       3
`endif

// File: tsr_sync.v
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module tsr_sync #(
    parameter RST_VAL = 1'b0
) (
    input  wire ref_clk,
    input  wire resetn,
    input  wire clk_en,
    input  wire din,
    output reg  dout
);
    reg stage1;

    // first stage feeds only the second
    always @(posedge ref_clk) begin
        if (!resetn) begin
            stage1 <= RST_VAL;
            dout   <= RST_VAL;
        end else if (clk_en) begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule // tsr_sync

// File: tsr_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module tsr_fifo #(
    parameter WIDTH = 14,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             ref_clk,
    input  wire             resetn,
    input  wire             clk_en,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            do_wr;
    wire            do_rd;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign do_wr     = in_valid & in_ready;
    assign do_rd     = out_valid & out_ready;

    // pointers wrap naturally since depth is a power of two
    always @(posedge ref_clk) begin
        if (!resetn) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else if (clk_en) begin
            if (do_wr) begin
                mem[wr_ptr] <= in_data;
                wr_ptr      <= wr_ptr + 1'b1;
            end
            if (do_rd)
                rd_ptr <= rd_ptr + 1'b1;
            if (do_wr && !do_rd)
                count <= count + 1'b1;
            else if (do_rd && !do_wr)
                count <= count - 1'b1;
        end
    end
endmodule // tsr_fifo

// File: tsr_host_model.sv
// host serial master model for the sensor port
`timescale 1ns/10ps
module tsr_host_model (
    output logic        cs_n,
    output logic        sclk,
    output logic        din,
    input  wire         dout,
    input  wire         dout_oe,
    output logic [15:0] rx,
    output logic        done
);
    logic [15:0] sh;
    int          b;
    // a released output reads as x, so stale data never passes
    wire         line = dout_oe ? dout : 1'bx;

    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        din = 1'b0;
        rx = 16'h0000;
        done = 1'b0;
    end

    // shift one bit in; every 16th bit hands a word out
    task automatic take();
        sh = {sh[14:0], line};
        b++;
        if (b % 16 == 0) begin
            rx = sh;
            done = 1'b1;
            #1 done = 1'b0;
        end
    endtask

    // clock idles high and stands still between frames
    task automatic xfer(input logic [15:0] tx, input int n);
        int i;
        #1.3;
        b = 0;
        cs_n = 1'b0;
        #100;
        for (i = 0; i < n; i++) begin
            sclk = 1'b0;
            if (i > 0) take();
            din = tx[15 - i % 16];
            #16;
            sclk = 1'b1;
            #16;
        end
        take();
        #20;
        cs_n = 1'b1;
        din = ~din;
        #200;
    endtask
endmodule // tsr_host_model

// File: tsr_top_properties.sv
// concurrent checks on the sensor readout ports
`timescale 1ns/10ps
module tsr_top_properties #(
    parameter [31:0] TICK_CYC = 1000,
    parameter [31:0] CONV_CYC = 400
) (
    input wire        ref_clk,
    input wire        resetn,
    input wire        clk_en,
    input wire        cs_n,
    input wire        sclk,
    input wire        din,
    input wire        dout,
    input wire        dout_oe,
    input wire [13:0] adc_code,
    input wire        analog_on,
    input wire        shutdown,
    input wire [13:0] temperature_value,
    input wire [15:0] control_word
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic [31:0] on_cnt;
    logic [31:0] idle_cnt;

    // conversion length and idle time; idle restarts on any access
    always @(posedge ref_clk) begin
        on_cnt <= (!resetn || !analog_on) ? 32'h0 : on_cnt + 32'h1;
        idle_cnt <= (!resetn || analog_on || shutdown || !cs_n) ? 32'h0 : idle_cnt + 32'h1;
    end

    property p_oe_off; cs_n [*4] |-> !dout_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("dout driven while deselected");
    property p_oe_on; !cs_n [*4] |-> dout_oe; endproperty
    a_oe_on: assert property (p_oe_on) else $error("dout not driven while selected");
    property p_sd_stop; shutdown && $past(shutdown) |-> !$rose(analog_on); endproperty
    a_sd_stop: assert property (p_sd_stop) else $error("conversion began in shutdown");
    property p_conv_len; $fell(analog_on) |-> on_cnt + 2 >= CONV_CYC && on_cnt <= CONV_CYC + 2; endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
    property p_tick; idle_cnt <= TICK_CYC + 8; endproperty
    a_tick: assert property (p_tick) else $error("no conversion within the tick");
    property p_val_cs; !$stable(temperature_value) |-> !$past(cs_n, 3); endproperty
    a_val_cs: assert property (p_val_cs) else $error("value changed outside access");
    property p_ctl_cs; !$stable(control_word) |-> !$past(cs_n, 3); endproperty
    a_ctl_cs: assert property (p_ctl_cs) else $error("control changed outside access");
    property p_sd_ctl; !$stable(shutdown) |-> shutdown == control_word[13]; endproperty
    a_sd_ctl: assert property (p_sd_ctl) else $error("shutdown differs from control");

    c_sd_on: cover property ($rose(shutdown));
    c_sd_off: cover property ($fell(shutdown));
    c_conv: cover property ($fell(analog_on));
endmodule // tsr_top_properties

bind tsr_top tsr_top_properties #(.TICK_CYC(TICK_CYC), .CONV_CYC(CONV_CYC)) prop_inst (
    .ref_clk, .resetn, .clk_en, .cs_n, .sclk, .din, .dout, .dout_oe, .adc_code,
    .analog_on, .shutdown, .temperature_value, .control_word
);

// File: tb_top.sv
// self-checking bench for the sensor readout block
`timescale 1ns/10ps
module tb_top;
    localparam [31:0] TICK = 32'd1000;
    localparam [31:0] CONV = 32'd400;
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [13:0] adc_code = 14'h0000;
    logic [13:0] code;
    logic [13:0] old;
    logic [15:0] expq[$];
    int          mismatches = 0;
    int          check_count = 0;
    wire         cs_n, sclk, din, dout, dout_oe, analog_on, shutdown, done;
    wire  [13:0] temperature_value;
    wire  [15:0] control_word, rx;

    always #2 ref_clk = ~ref_clk;

    tsr_top #(.TICK_CYC(TICK), .CONV_CYC(CONV)) tsr_top_inst (
        .ref_clk(ref_clk), .resetn(resetn), .clk_en(1'b1), .cs_n(cs_n), .sclk(sclk),
        .din(din), .dout(dout), .dout_oe(dout_oe), .adc_code(adc_code),
        .analog_on(analog_on), .shutdown(shutdown),
        .temperature_value(temperature_value), .control_word(control_word)
    );
    tsr_host_model tsr_host_model_inst (
        .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe),
        .rx(rx), .done(done)
    );

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // each word the host collects is matched against the oldest note
    always @(posedge done) begin
        chk("rx_word", rx, expq.size() ? expq.pop_front() : 16'hdead);
    end

    // one note per whole 16-bit word; cut frames leave none
    task automatic rd(input logic [15:0] tx, input int n, input logic [13:0] v);
        int i;
        for (i = 0; i < n / 16; i++) expq.push_back({2'b00, v});
        tsr_host_model_inst.xfer(tx, n);
    endtask

    // bounded wait on the analog power flag, stepping off the edges
    task automatic wconv(input logic v, input int n);
        int k;
        for (k = 0; k < n && analog_on !== v; k++) #4;
        chk("analog_on", 16'(analog_on), 16'(v));
    endtask

    // the code moves at a clock edge, at times while a conversion runs that samples it at its end
    task automatic newcode();
        @(posedge ref_clk);
        code = 14'($urandom);
        adc_code <= code;
        #1;
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        void'($urandom(32'h809b8248));
        newcode();
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        #1;
        wconv(1'b1, 4);
        wconv(1'b0, CONV + 8);
        chk("value", 16'(temperature_value), 16'h0000);
        rd(16'h0000, 16, code);
        chk("value", 16'(temperature_value), 16'(code));
        wconv(1'b1, 16);
        old = code;
        newcode();
        rd(16'h0000, 32, old);
        wconv(1'b0, CONV + 8);
        rd(16'h2000, 8, code);
        chk("shutdown", 16'(shutdown), 16'h0000);
        chk("control", control_word, 16'h0000);
        wconv(1'b0, CONV + 8);
        rd(16'h2000, 16, code);
        chk("shutdown", 16'(shutdown), 16'h0001);
        chk("control", control_word, 16'h2000);
        old = code;
        newcode();
        #(TICK * 8);
        chk("analog_on", 16'(analog_on), 16'h0000);
        rd(16'h2000, 16, old);
        rd(16'h0000, 16, old);
        chk("shutdown", 16'(shutdown), 16'h0000);
        wconv(1'b1, 16);
        wconv(1'b0, CONV + 8);
        rd(16'h0000, 16, code);
        wconv(1'b1, 16);
        wconv(1'b0, CONV + 8);
        wconv(1'b1, TICK + 16);
        #2000;
        wrap_up();
    end

    // cut a hang short
    initial begin
        #200000;
        mismatches++;
        wrap_up();
    end
endmodule // tb_top
